// [hdl/acrp_pkg.sv]
/*
  package for the converter readout controller: counts, codes, timing.
  assumes a 250 MHz system clock and a converter that answers with a
  short low end-of-conversion pulse.
*/
`default_nettype none
package acrp_pkg;
  localparam int unsigned CLK_PERIOD_PS = 4000; // 4 ns system clock
  localparam int unsigned RESULT_BITS = 12;
  localparam int unsigned LEAD_ZEROS = 4;
  localparam int unsigned FRAME_BITS = 16;
  // start pulse low time, least, in ns
  localparam int unsigned START_LOW_NS = 40;
  localparam int unsigned START_LOW_CYC =
    (START_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // read strobe low time, least, in ns
  localparam int unsigned READ_LOW_NS = 40;
  localparam int unsigned READ_LOW_CYC =
    (READ_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // serial clock half period made by the divider
  localparam int unsigned SCLK_HALF_CYC = 20;
  localparam logic [11:0] RESULT_RST = 12'h000;
  localparam logic [11:0] BIPOLAR_FLIP = 12'h800;
  localparam logic [11:0] CODE_LOW_UNI = 12'h000;
  localparam logic [11:0] CODE_MAX_UNI = 12'hFFF;
  localparam logic [11:0] CODE_MAX_BI = 12'h7FF;
  localparam logic [11:0] CODE_MIN_BI = 12'h800;
  typedef enum logic [2:0] {
    ACRP_IDLE = 3'b000,
    ACRP_START = 3'b001,
    ACRP_WAIT = 3'b010,
    ACRP_PREAD = 3'b011,
    ACRP_SHIFT = 3'b100,
    ACRP_DONE = 3'b101
  } acrp_state_t;
endpackage : acrp_pkg
`default_nettype wire

// [hdl/acrp_sync.sv]
/*
  two flip-flop synchroniser, one per bit, for pins from the converter.
  assumes inputs are asynchronous to i_clk.
*/
`default_nettype none
module acrp_sync #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } acrp_sync_st_t;
  acrp_sync_st_t st_r;
  acrp_sync_st_t st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt.meta = i_async;
    st_nxt.sync = st_r.meta;
  end

  // registers; idle pins read high
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.sync;
endmodule : acrp_sync
`default_nettype wire

// [hdl/acrp_host.sv]
/*
  host controller for a 12-bit converter: starts conversions, waits for
  the end-of-conversion pulse, reads the result over the parallel bus or
  the serial link, and hands a normalised word to the user.
  assumes converter pins are asynchronous and pass through acrp_sync.
*/
// Behaviour
// R01 - parallel mode: bits 4,3 are data; serial: shift clock and frame sync
// R02 - host supplies shift clock; device shifts on its rising edges
// R03 - host drives frame sync low to start each serial transfer
// R04 - bipolar parts two's complement, unipolar part straight binary
// R05 - parallel outputs enabled only while read and chip select both low
// R06 - end of conversion is one low pulse, about 100 ns, idles high
// R07 - rising edge on convert start begins a conversion
// R08 - parallel bus carries least significant bit on bit 0
// R09 - bipolar: most positive 01..1, most negative 10..0
// R10 - unipolar: 00..0 at bottom, 11..1 at full scale
// R11 - mode input low selects serial, high selects parallel
// R12 - serial frame: four zeros then twelve bits, sampled on falling edges
// R13 - mode held static between start and completed readout
`default_nettype none
module acrp_host #(
  parameter int unsigned SCLK_HALF = acrp_pkg::SCLK_HALF_CYC,
  parameter bit BIPOLAR = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire logic i_serial_sel,
  input wire logic i_eoc_b,
  input wire logic [11:0] i_db,
  input wire logic i_serial_result_out,
  output logic o_convert_start,
  output logic o_mode,
  output logic o_rd_b,
  output logic o_cs_b,
  output logic o_shift_clock,
  output logic o_frame_sync_b,
  output logic o_busy,
  output logic o_valid,
  output logic [11:0] o_result,
  output logic [11:0] o_offset_result
);
  typedef struct packed {
    acrp_pkg::acrp_state_t state;
    logic serial;
    logic [7:0] cnt;
    logic [4:0] bits;
    logic [15:0] shreg;
    logic conv;
    logic rd_b;
    logic sclk;
    logic fs_b;
    logic valid;
    logic [11:0] result;
    logic [11:0] offres;
    logic eoc_d;
    logic cs_b;
    logic mode;
    logic busy;
  } acrp_st_t;
  acrp_st_t st_r;
  acrp_st_t st_nxt;
  logic eoc_s;
  logic sdo_s;
  logic [11:0] db_s;
  logic eoc_fall;
  logic [11:0] word;

  // all converter pins pass two flops
  acrp_sync #(.WIDTH(14)) u_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async({i_eoc_b, i_serial_result_out, i_db}),
    .o_sync({eoc_s, sdo_s, db_s})
  );

  assign eoc_fall = st_r.eoc_d & ~eoc_s; // R06
  assign word = st_r.serial ? st_r.shreg[11:0] : db_s; // R08 R12

  // sequence control
  always_comb begin
    st_nxt = st_r;
    st_nxt.eoc_d = eoc_s;
    st_nxt.valid = 1'b0;
    case (st_r.state)
      acrp_pkg::ACRP_IDLE: begin
        st_nxt.serial = i_serial_sel; // R11 R13
        if (i_start) begin
          st_nxt.conv = 1'b0;
          st_nxt.cnt = 8'(acrp_pkg::START_LOW_CYC);
          st_nxt.state = acrp_pkg::ACRP_START;
        end
      end
      acrp_pkg::ACRP_START: begin
        if (st_r.cnt <= 8'h01) begin
          st_nxt.conv = 1'b1; // R07
          st_nxt.state = acrp_pkg::ACRP_WAIT;
        end else begin
          st_nxt.cnt = st_r.cnt - 8'h01;
        end
      end
      acrp_pkg::ACRP_WAIT: begin
        if (eoc_fall && !st_r.serial) begin
          st_nxt.rd_b = 1'b0; // R05
          st_nxt.cs_b = 1'b0; // R05
          st_nxt.cnt = 8'(acrp_pkg::READ_LOW_CYC + 2);
          st_nxt.state = acrp_pkg::ACRP_PREAD;
        end else if (eoc_fall) begin
          st_nxt.fs_b = 1'b0; // R03
          st_nxt.bits = 5'h00;
          st_nxt.cnt = 8'(SCLK_HALF);
          st_nxt.state = acrp_pkg::ACRP_SHIFT;
        end
      end
      acrp_pkg::ACRP_PREAD: begin
        if (st_r.cnt <= 8'h01) begin
          st_nxt.rd_b = 1'b1;
          st_nxt.cs_b = 1'b1; // R05
          st_nxt.state = acrp_pkg::ACRP_DONE;
        end else begin
          st_nxt.cnt = st_r.cnt - 8'h01;
        end
      end
      acrp_pkg::ACRP_SHIFT: begin
        // divider makes the shift clock; sample on our falling edge
        if (st_r.cnt <= 8'h01) begin
          st_nxt.cnt = 8'(SCLK_HALF);
          st_nxt.sclk = ~st_r.sclk; // R02
          if (st_r.sclk) begin
            st_nxt.shreg = {st_r.shreg[14:0], sdo_s}; // R12
            st_nxt.bits = st_r.bits + 5'h01;
            if (st_r.bits == 5'(acrp_pkg::FRAME_BITS - 1)) begin
              st_nxt.fs_b = 1'b1;
              st_nxt.state = acrp_pkg::ACRP_DONE;
            end
          end
        end else begin
          st_nxt.cnt = st_r.cnt - 8'h01;
        end
      end
      acrp_pkg::ACRP_DONE: begin
        st_nxt.valid = 1'b1;
        st_nxt.result = word; // R04
        // offset binary view: flip sign bit for bipolar codes
        st_nxt.offres = BIPOLAR ? (word ^ acrp_pkg::BIPOLAR_FLIP) : word; // R09 R10
        st_nxt.state = acrp_pkg::ACRP_IDLE;
      end
      default: st_nxt.state = acrp_pkg::ACRP_IDLE;
    endcase
    // mode pin and busy flag follow the next state, so both leave flops
    st_nxt.mode = ~st_nxt.serial; // R11 R13
    st_nxt.busy = (st_nxt.state != acrp_pkg::ACRP_IDLE);
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r.state <= acrp_pkg::ACRP_IDLE;
      st_r.serial <= 1'b0;
      st_r.cnt <= 8'h00;
      st_r.bits <= 5'h00;
      st_r.shreg <= 16'h0000;
      st_r.conv <= 1'b1;
      st_r.rd_b <= 1'b1;
      st_r.sclk <= 1'b0;
      st_r.fs_b <= 1'b1;
      st_r.valid <= 1'b0;
      st_r.result <= acrp_pkg::RESULT_RST;
      st_r.offres <= acrp_pkg::RESULT_RST;
      st_r.eoc_d <= 1'b1;
      st_r.cs_b <= 1'b1;
      st_r.mode <= 1'b1;
      st_r.busy <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // pin and user outputs, straight from flops
  assign o_convert_start = st_r.conv;
  assign o_mode = st_r.mode; // R11
  assign o_rd_b = st_r.rd_b;
  assign o_cs_b = st_r.cs_b; // R05
  assign o_shift_clock = st_r.sclk; // R01
  assign o_frame_sync_b = st_r.fs_b; // R01
  assign o_busy = st_r.busy;
  assign o_valid = st_r.valid;
  assign o_result = st_r.result;
  assign o_offset_result = st_r.offres;

  // convert start low two cycles before its rising edge
  AST_START_LOW: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(st_r.conv) |-> $past(st_r.conv, 2) == 1'b0) // R07
    else $error("convert start high too soon");
  // read and select fall together
  AST_RD_CS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_rd_b == o_cs_b) // R05
    else $error("read and select differ");
  // frame sync low throughout shifting
  AST_FS_LOW: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st_r.state == acrp_pkg::ACRP_SHIFT |-> !o_frame_sync_b) // R03
    else $error("frame sync high while shifting");
  // shift clock idle low outside a frame
  AST_SCLK_IDLE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_frame_sync_b |-> !o_shift_clock) // R02
    else $error("shift clock runs outside frame");
  // a frame ends after sixteen bits
  AST_FRAME_LEN: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_frame_sync_b) |-> st_r.bits == 5'h10) // R12
    else $error("frame length not sixteen");
  // eoc fall in serial mode opens a frame next cycle
  AST_EOC_FRAME: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st_r.state == acrp_pkg::ACRP_WAIT && eoc_fall && st_r.serial
    |=> $fell(o_frame_sync_b)) // R06
    else $error("no frame after end of conversion");
  // mode pin stable while busy
  AST_MODE_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_busy && $past(o_busy) |-> $stable(o_mode)) // R13
    else $error("mode changed mid conversion");
  // offset view is the sign-flipped result in bipolar builds
  AST_CODING: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_valid |-> o_offset_result ==
      (BIPOLAR ? (o_result ^ acrp_pkg::BIPOLAR_FLIP) : o_result)) // R04
    else $error("coding mismatch");
endmodule : acrp_host
`default_nettype wire

// [testbench/acrp_conv_model.sv]
/*
  behavioural converter on the far side of the readout controller.
  assumes the host drives start, mode, read, select and the serial pins.
*/
`default_nettype none
module acrp_conv_model #(
  parameter int CONV_NS = 400,
  parameter int EOC_NS = 100
) (
  input wire logic i_convert_start,
  input wire logic i_mode,
  input wire logic i_rd_b,
  input wire logic i_cs_b,
  input wire logic i_shift_clock,
  input wire logic i_frame_sync_b,
  input wire logic [11:0] i_code,
  output logic o_eoc_b,
  output logic [11:0] o_db,
  output logic o_serial_result_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] res = 12'h000;
  logic [3:0] cnt = 4'hF;
  logic sd = 1'b0;
  logic [15:0] frame;
  logic conv_d = 1'b1;
  event go;
  initial o_eoc_b = 1'b1;
  // only a true low-to-high start edge counts, not the power-up settle
  always @(i_convert_start) begin
    if (conv_d === 1'b0 && i_convert_start === 1'b1) begin
      -> go;
    end
    conv_d = i_convert_start;
  end
  // convert on the rising start edge, then one low pulse
  always @(go) begin
    #(CONV_NS) res = i_code;
    o_eoc_b = 1'b0;
    #(EOC_NS) o_eoc_b = 1'b1;
  end
  // parallel bus; released lines show the inverse
  assign o_db = (!i_rd_b && !i_cs_b && i_mode) ? res : ~res;
  // serial frame, four zeros then the code
  assign frame = {4'h0, res};
  always @(negedge i_frame_sync_b) cnt = 4'hF;
  always @(posedge i_shift_clock) begin
    if (!i_frame_sync_b && !i_mode) begin
      sd = frame[cnt];
      cnt = cnt - 4'h1;
    end
  end
  always @(posedge i_frame_sync_b) sd = ~sd; // line not held after frame
  assign o_serial_result_out = sd;
endmodule : acrp_conv_model
`default_nettype wire

// [testbench/acrp_host_bench.sv]
/*
  self-checking bench for acrp_host against the converter model.
  assumes the model file is compiled first.
*/
`default_nettype none
module acrp_host_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_start = 1'b0;
  logic i_serial_sel = 1'b0;
  logic [11:0] code = 12'h000;
  logic eoc_b, serial_result_out, cs, mode, rd_b, cs_b, sck, fs_b, busy, valid;
  logic [11:0] db, res, ofs;
  logic [11:0] q_raw[$];
  logic [11:0] q_ofs[$];
  logic q_mode[$];
  logic m;
  logic [11:0] e;
  logic [31:0] seed = 32'h72f6270f;
  logic [11:0] tbl[6] = '{12'h000, 12'h001, 12'hFFF, 12'h7FF, 12'h800,
    12'hA5C};
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int k;
  always #2 i_clk = ~i_clk;
  acrp_host #(.SCLK_HALF(5)) uut (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_start(i_start), .i_serial_sel(i_serial_sel), .i_eoc_b(eoc_b),
    .i_db(db), .i_serial_result_out(serial_result_out), .o_convert_start(cs),
    .o_mode(mode), .o_rd_b(rd_b), .o_cs_b(cs_b), .o_shift_clock(sck),
    .o_frame_sync_b(fs_b), .o_busy(busy), .o_valid(valid),
    .o_result(res), .o_offset_result(ofs));
  acrp_conv_model model (.i_convert_start(cs), .i_mode(mode),
    .i_rd_b(rd_b), .i_cs_b(cs_b), .i_shift_clock(sck),
    .i_frame_sync_b(fs_b), .i_code(code), .o_eoc_b(eoc_b), .o_db(db),
    .o_serial_result_out(serial_result_out));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [11:0] seen,
    input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report;
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  // result monitor: oldest note against each valid pulse
  always @(posedge i_clk) begin
    if (valid === 1'b1) begin
      e = (q_raw.size() > 0) ? q_raw.pop_front() : 12'hXXX;
      chk("result", res, e);
      e = (q_ofs.size() > 0) ? q_ofs.pop_front() : 12'hXXX;
      chk("offset", ofs, e);
      m = (q_mode.size() > 0) ? q_mode.pop_front() : 1'hX;
      chk("mode", 12'(mode), 12'(m));
      chk("busy", 12'(busy), 12'h000);
    end
  end
  // hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  // conversions in both modes, boundary codes then random ones
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (k = 0; k < 20; k++) begin
      seed = xs(seed);
      code <= (k < 6) ? tbl[k] : seed[11:0];
      @(posedge i_clk);
      q_raw.push_back(code);
      q_ofs.push_back(code ^ 12'h800);
      i_start <= 1'b1;
      i_serial_sel <= k[0] ^ seed[20];
      q_mode.push_back(~(k[0] ^ seed[20]));
      @(posedge i_clk);
      i_start <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_start <= (k == 3); // ignored while busy
      @(posedge i_clk);
      i_start <= 1'b0;
      while (busy !== 1'b0) @(posedge i_clk);
      repeat (seed[3:0]) @(posedge i_clk);
    end
    repeat (4) @(posedge i_clk);
    chk("pending", 12'(q_raw.size()), 12'h000);
    final_report();
  end
endmodule : acrp_host_bench
`default_nettype wire
